// ==== ccp_parser.sv ====
// command interpreter with reply fifo and axi4-lite register slave
// Summary of operation
// RULE1 - Z CR LF answers Z, space, filtered reading in five digits, CR LF
// RULE2 - z CR LF answers z, space, unfiltered reading in five digits, CR LF
// RULE3 - host multiplies readings by the scale factor to get ppm
// RULE4 - period CR LF answers period, space, scale multiplier five digits
// RULE5 - multiplier is 10 for the 60 percent range, 100 for 100 percent
// RULE6 - host divides concentrations by the scale factor before sending
// RULE7 - K space digit CR LF sets mode, echoed as five digits
// RULE8 - sleep mode makes no measurements and answers without delay
// RULE9 - sleep mode disables measurement reporting and zero-point commands
// RULE10 - sleep mode is not kept across a power cycle
// RULE11 - streaming, mode one, is the factory default
// RULE12 - streaming mode sends unsolicited reports twice per second
// RULE13 - streaming mode defers commands while a measurement is running
// RULE14 - polling mode measures but only answers requests
// RULE15 - power-up resumes the last streaming or polling mode
// RULE16 - A sets the filter value, default 16, echoed as five digits
// RULE17 - a CR LF answers the filter value in five digits
// RULE18 - malformed or unknown input is dropped silently, settings unchanged
`timescale 1ns/100ps
`include "ccp_consts.svh"

// ----------------------------------------
// reply fifo
// ----------------------------------------
module ccp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    logic wr;
    logic rd;
    assign in_ready = cnt_r != (AW+1)'(DEPTH);
    assign out_valid = cnt_r != '0;
    assign out_data = mem_r[rp_r];
    assign wr = in_valid && in_ready;
    assign rd = out_valid && out_ready;
    always_ff @(posedge aclk) begin
        if (wr) begin
            mem_r[wp_r] <= in_data;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            if (wr) begin
                wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
            end
            if (rd) begin
                rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
            end
            cnt_r <= cnt_r + (AW+1)'(wr) - (AW+1)'(rd);
        end
    end
endmodule

// ----------------------------------------
// interpreter top
// ----------------------------------------
module ccp_parser #(
    parameter int REPORT_CYCLES =
        `STREAM_PERIOD_MS * `NS_PER_MS / `CLK_PERIOD_NS
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic rx_valid,
    output logic rx_ready,
    input wire logic [7:0] rx_data,
    output logic tx_valid,
    input wire logic tx_ready,
    output logic [7:0] tx_data,
    input wire ccp_pkg::ccp_meas_t meas,
    input wire logic meas_busy,
    output logic meas_en,
    input wire logic saved_poll,
    output logic save_poll,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    ccp_pkg::ccp_state_t state_r;
    ccp_pkg::ccp_cmd_t cmd_r;
    logic [1:0] mode_r;
    logic [15:0] filter_r;
    logic wide_r;
    logic first_r;
    logic save_poll_r;
    logic [7:0] buf_r [`RESP_LEN];
    logic [3:0] idx_r;
    logic busy_r;
    logic pend_r;
    logic [31:0] tick_r;
    logic rx_fire;
    logic is_digit;
    logic needs_arg;
    logic known;
    logic defer;
    logic go;
    logic cmd_ok;
    logic stream_start;
    logic fifo_ready;
    logic [15:0] resp_val;
    logic [16:0] arg_nxt;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [7:0] dec_char(input logic [15:0] v,
                                            input logic [2:0] pos);
        logic [16:0] q;
        q = {1'b0, v};
        for (int i = 0; i < 5; i++) begin
            if (3'(i) < pos) begin
                q = q / `DEC_BASE;
            end
        end
        return 8'(q % `DEC_BASE) + `CH_0;
    endfunction

    assign rx_ready = state_r != ccp_pkg::ST_EXEC;
    assign rx_fire = rx_valid && rx_ready;
    assign is_digit = rx_data >= `CH_0 && rx_data <= `CH_9;
    assign needs_arg = rx_data == `CH_MODE || rx_data == `CH_FSET;
    assign known = needs_arg || rx_data == `CH_FILT ||
        rx_data == `CH_RAW || rx_data == `CH_SCALE || rx_data == `CH_FGET;
    assign arg_nxt = (cmd_r.arg > `ARG_SAT_LIM) ? `ARG_SAT :
        17'(cmd_r.arg * `DEC_BASE + 17'(rx_data - `CH_0));
    // polling or sleep answers at once; streaming waits for the chain
    assign defer = mode_r == `MODE_STREAM && meas_busy; // [RULE13] [RULE8]
    assign go = state_r == ccp_pkg::ST_EXEC && !busy_r && !defer;
    assign meas_en = mode_r != `MODE_SLEEP; // [RULE8] [RULE14]
    assign save_poll = save_poll_r;

    always_comb begin
        cmd_ok = 1'b0;
        resp_val = '0;
        unique case (cmd_r.code)
            `CH_FILT: begin
                cmd_ok = mode_r != `MODE_SLEEP; // [RULE1] [RULE9]
                resp_val = meas.filt;
            end
            `CH_RAW: begin
                cmd_ok = mode_r != `MODE_SLEEP; // [RULE2] [RULE9]
                resp_val = meas.raw;
            end
            `CH_SCALE: begin
                cmd_ok = 1'b1; // [RULE4]
                resp_val = wide_r ? `SCALE_WIDE : `SCALE_NARROW; // [RULE5]
            end
            `CH_MODE: begin
                cmd_ok = cmd_r.arg <= 17'(`MODE_POLL); // [RULE7] [RULE18]
                resp_val = 16'(cmd_r.arg);
            end
            `CH_FSET: begin
                cmd_ok = cmd_r.arg >= `FILT_MIN &&
                    cmd_r.arg <= `FILT_MAX; // [RULE16] [RULE18]
                resp_val = 16'(cmd_r.arg);
            end
            `CH_FGET: begin
                cmd_ok = 1'b1; // [RULE17]
                resp_val = filter_r;
            end
            default: begin
                cmd_ok = 1'b0;
                resp_val = '0;
            end
        endcase
    end

    // ----------------------------------------
    // character parser
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= ccp_pkg::ST_CMD;
            cmd_r <= '0;
        end else begin
            unique case (state_r)
                ccp_pkg::ST_CMD: begin
                    if (rx_fire) begin
                        cmd_r.code <= rx_data;
                        cmd_r.arg <= '0;
                        cmd_r.has_arg <= 1'b0;
                        if (rx_data == `CH_LF) begin
                            state_r <= ccp_pkg::ST_CMD;
                        end else if (known) begin
                            state_r <= ccp_pkg::ST_SEP;
                        end else begin
                            state_r <= ccp_pkg::ST_DROP; // [RULE18]
                        end
                    end
                end
                ccp_pkg::ST_SEP: begin
                    if (rx_fire) begin
                        if (rx_data == `CH_SP && needs_arg_of(cmd_r.code)) begin
                            state_r <= ccp_pkg::ST_ARG;
                        end else if (rx_data == `CH_CR &&
                                     !needs_arg_of(cmd_r.code)) begin
                            state_r <= ccp_pkg::ST_LF;
                        end else begin
                            state_r <= rx_data == `CH_LF ?
                                ccp_pkg::ST_CMD : ccp_pkg::ST_DROP;
                        end
                    end
                end
                ccp_pkg::ST_ARG: begin
                    if (rx_fire) begin
                        if (is_digit) begin
                            cmd_r.arg <= arg_nxt;
                            cmd_r.has_arg <= 1'b1;
                        end else if (rx_data == `CH_CR && cmd_r.has_arg) begin
                            state_r <= ccp_pkg::ST_LF;
                        end else begin
                            state_r <= rx_data == `CH_LF ?
                                ccp_pkg::ST_CMD : ccp_pkg::ST_DROP;
                        end
                    end
                end
                ccp_pkg::ST_LF: begin
                    if (rx_fire) begin
                        state_r <= rx_data == `CH_LF ?
                            ccp_pkg::ST_EXEC : ccp_pkg::ST_DROP;
                    end
                end
                ccp_pkg::ST_DROP: begin
                    // resync on the next line feed
                    if (rx_fire && rx_data == `CH_LF) begin
                        state_r <= ccp_pkg::ST_CMD; // [RULE18]
                    end
                end
                ccp_pkg::ST_EXEC: begin
                    if (go) begin
                        state_r <= ccp_pkg::ST_CMD;
                    end
                end
                default: begin
                    state_r <= ccp_pkg::ST_CMD;
                end
            endcase
        end
    end

    function automatic logic needs_arg_of(input logic [7:0] c);
        return c == `CH_MODE || c == `CH_FSET;
    endfunction

    // ----------------------------------------
    // settings
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_r <= `MODE_STREAM; // [RULE11] [RULE10]
            first_r <= 1'b1;
            save_poll_r <= 1'b0;
        end else begin
            first_r <= 1'b0;
            if (first_r) begin
                // strap caught after release, never sleep
                mode_r <= saved_poll ? `MODE_POLL : `MODE_STREAM; // [RULE15]
                save_poll_r <= saved_poll;
            end else if (go && cmd_ok && cmd_r.code == `CH_MODE) begin
                mode_r <= 2'(cmd_r.arg); // [RULE7]
                if (cmd_r.arg != 17'(`MODE_SLEEP)) begin
                    save_poll_r <= cmd_r.arg == 17'(`MODE_POLL); // [RULE15]
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            filter_r <= `FILT_DEF;
        end else if (go && cmd_ok && cmd_r.code == `CH_FSET) begin
            filter_r <= 16'(cmd_r.arg); // [RULE16]
        end
    end

    // ----------------------------------------
    // streaming report timer
    // ----------------------------------------
    assign stream_start = pend_r && !busy_r &&
        state_r != ccp_pkg::ST_EXEC && mode_r == `MODE_STREAM; // [RULE14]
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_r <= '0;
            pend_r <= 1'b0;
        end else begin
            if (mode_r != `MODE_STREAM) begin
                tick_r <= '0;
                pend_r <= 1'b0;
            end else if (tick_r == 32'(REPORT_CYCLES - 1)) begin
                tick_r <= '0;
                pend_r <= 1'b1; // [RULE12]
            end else begin
                tick_r <= tick_r + 32'h1;
                pend_r <= pend_r && !stream_start;
            end
        end
    end

    // ----------------------------------------
    // reply emitter, stalls on a full fifo
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            busy_r <= 1'b0;
            idx_r <= '0;
            for (int i = 0; i < `RESP_LEN; i++) begin
                buf_r[i] <= '0;
            end
        end else if (go && cmd_ok || stream_start) begin
            busy_r <= 1'b1;
            idx_r <= '0;
            buf_r[0] <= stream_start ? `CH_FILT : cmd_r.code;
            buf_r[1] <= `CH_SP;
            for (int i = 0; i < 5; i++) begin
                buf_r[2 + i] <= dec_char(stream_start ? meas.filt : resp_val,
                                         3'(4 - i));
            end
            buf_r[7] <= `CH_CR;
            buf_r[8] <= `CH_LF;
        end else if (busy_r && fifo_ready) begin
            idx_r <= idx_r + 4'h1;
            busy_r <= idx_r != `RESP_LAST;
        end
    end

    ccp_fifo #(
        .WIDTH(8),
        .DEPTH(8)
    ) u_fifo (
        .aclk(aclk),
        .aresetn(aresetn),
        .in_valid(busy_r),
        .in_ready(fifo_ready),
        .in_data(buf_r[idx_r]),
        .out_valid(tx_valid),
        .out_ready(tx_ready),
        .out_data(tx_data)
    );

    // ----------------------------------------
    // axi4-lite slave
    // ----------------------------------------
    logic aw_got_r;
    logic w_got_r;
    logic [3:0] awa_r;
    logic aw_bad_r;
    logic [31:0] wd_r;
    logic [3:0] ws_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            awa_r <= '0;
            aw_bad_r <= 1'b0;
            wd_r <= '0;
            ws_r <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `AXI_OKAY;
            wide_r <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_r <= 1'b1;
                awa_r <= s_axi_awaddr[3:0];
                aw_bad_r <= s_axi_awaddr[31:4] != '0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_r <= 1'b1;
                wd_r <= s_axi_wdata;
                ws_r <= s_axi_wstrb;
            end
            if (aw_got_r && w_got_r && !s_axi_bvalid) begin
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (!aw_bad_r && awa_r == `REG_CTRL) begin
                    s_axi_bresp <= `AXI_OKAY;
                    if (ws_r[0]) begin
                        wide_r <= wd_r[`CTRL_WIDE_BIT]; // [RULE5]
                    end
                end else begin
                    s_axi_bresp <= (!aw_bad_r && (awa_r == `REG_STATUS ||
                        awa_r == `REG_FILTER)) ? `AXI_OKAY : `AXI_SLVERR;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
    assign s_axi_wready = !w_got_r && !s_axi_bvalid;

    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= `AXI_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `AXI_OKAY;
            s_axi_rdata <= '0;
            if (s_axi_araddr[31:4] != '0) begin
                s_axi_rresp <= `AXI_SLVERR;
            end else if (s_axi_araddr[3:0] == `REG_CTRL) begin
                s_axi_rdata <= {31'h0, wide_r};
            end else if (s_axi_araddr[3:0] == `REG_STATUS) begin
                s_axi_rdata <= {26'h0, state_r == ccp_pkg::ST_EXEC,
                    busy_r, pend_r, save_poll_r, mode_r};
            end else if (s_axi_araddr[3:0] == `REG_FILTER) begin
                s_axi_rdata <= {16'h0, filter_r};
            end else begin
                s_axi_rresp <= `AXI_SLVERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    property p_filt_reply;
        @(posedge aclk) disable iff (!aresetn)
        go && cmd_ok && cmd_r.code == `CH_FILT |=>
            buf_r[0] == `CH_FILT && buf_r[1] == `CH_SP &&
            buf_r[6] == dec_char($past(meas.filt), 3'h0) &&
            buf_r[8] == `CH_LF;
    endproperty
    a_filt_reply: assert property (p_filt_reply) // [RULE1]
        else $error("filtered reply malformed");
    property p_raw_reply;
        @(posedge aclk) disable iff (!aresetn)
        go && cmd_ok && cmd_r.code == `CH_RAW |=>
            buf_r[0] == `CH_RAW && buf_r[7] == `CH_CR;
    endproperty
    a_raw_reply: assert property (p_raw_reply) // [RULE2]
        else $error("unfiltered reply malformed");
    property p_scale;
        @(posedge aclk) disable iff (!aresetn)
        go && cmd_r.code == `CH_SCALE |=>
            buf_r[0] == `CH_SCALE && buf_r[5] == ($past(wide_r) ?
            `CH_0 : `CH_0 + 8'h1) && buf_r[6] == `CH_0;
    endproperty
    a_scale: assert property (p_scale) // [RULE4]
        else $error("scale reply wrong");
    property p_mode_set;
        @(posedge aclk) disable iff (!aresetn)
        go && cmd_ok && cmd_r.code == `CH_MODE |=>
            mode_r == 2'($past(cmd_r.arg)) ##1 busy_r;
    endproperty
    a_mode_set: assert property (p_mode_set) // [RULE7]
        else $error("mode not applied");
    property p_sleep_block;
        @(posedge aclk) disable iff (!aresetn)
        state_r == ccp_pkg::ST_EXEC && mode_r == `MODE_SLEEP &&
            cmd_r.code == `CH_FILT && !busy_r |=> !busy_r;
    endproperty
    a_sleep_block: assert property (p_sleep_block) // [RULE9]
        else $error("reading reported in sleep");
    property p_sleep_fast;
        @(posedge aclk) disable iff (!aresetn)
        state_r == ccp_pkg::ST_EXEC && mode_r != `MODE_STREAM &&
            !busy_r |=> state_r == ccp_pkg::ST_CMD;
    endproperty
    a_sleep_fast: assert property (p_sleep_fast) // [RULE8]
        else $error("command delayed outside streaming");
    property p_defer;
        @(posedge aclk) disable iff (!aresetn)
        state_r == ccp_pkg::ST_EXEC && defer |=>
            state_r == ccp_pkg::ST_EXEC && !rx_ready;
    endproperty
    a_defer: assert property (p_defer) // [RULE13]
        else $error("command run during measurement");
    property p_poll_quiet;
        @(posedge aclk) disable iff (!aresetn)
        mode_r == `MODE_POLL && !busy_r &&
            state_r != ccp_pkg::ST_EXEC |=> !busy_r;
    endproperty
    a_poll_quiet: assert property (p_poll_quiet) // [RULE14]
        else $error("unsolicited output in polling");
    property p_power_mode;
        @(posedge aclk) disable iff (!aresetn)
        aresetn && first_r |=> mode_r ==
            ($past(saved_poll) ? `MODE_POLL : `MODE_STREAM);
    endproperty
    a_power_mode: assert property (p_power_mode) // [RULE15]
        else $error("power-up mode wrong");
    property p_filter_set;
        @(posedge aclk) disable iff (!aresetn)
        go && cmd_ok && cmd_r.code == `CH_FSET |=>
            filter_r == 16'($past(cmd_r.arg));
    endproperty
    a_filter_set: assert property (p_filter_set) // [RULE16]
        else $error("filter not stored");
    property p_drop;
        @(posedge aclk) disable iff (!aresetn)
        state_r == ccp_pkg::ST_DROP |=> state_r != ccp_pkg::ST_EXEC;
    endproperty
    a_drop: assert property (p_drop) // [RULE18]
        else $error("bad line executed");
    c_stream: cover property (@(posedge aclk) disable iff (!aresetn)
        stream_start);
    c_filt: cover property (@(posedge aclk) disable iff (!aresetn)
        go && cmd_ok && cmd_r.code == `CH_FILT);
    c_defer: cover property (@(posedge aclk) disable iff (!aresetn)
        state_r == ccp_pkg::ST_EXEC && defer ##1 go);
endmodule

// ==== ccp_consts.svh ====
// constants for the gas sensor command interpreter
`ifndef CCP_CONSTS_SVH
`define CCP_CONSTS_SVH
// ----------------------------------------
// ascii characters
// ----------------------------------------
`define CH_FILT 8'h5a
`define CH_RAW 8'h7a
`define CH_SCALE 8'h2e
`define CH_MODE 8'h4b
`define CH_FSET 8'h41
`define CH_FGET 8'h61
`define CH_SP 8'h20
`define CH_CR 8'h0d
`define CH_LF 8'h0a
`define CH_0 8'h30
`define CH_9 8'h39
// ----------------------------------------
// values
// ----------------------------------------
`define DEC_BASE 17'h0000a
`define ARG_SAT_LIM 17'h03332
`define ARG_SAT 17'h1ffff
`define FILT_MAX 17'h0ffff
`define FILT_MIN 17'h00001
`define FILT_DEF 16'h0010
`define SCALE_NARROW 16'h000a
`define SCALE_WIDE 16'h0064
`define MODE_SLEEP 2'h0
`define MODE_STREAM 2'h1
`define MODE_POLL 2'h2
`define RESP_LEN 4'h9
`define RESP_LAST 4'h8
// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS 4
`define STREAM_PERIOD_MS 500
`define NS_PER_MS 1000000
// ----------------------------------------
// register map
// ----------------------------------------
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define REG_FILTER 4'h8
`define CTRL_WIDE_BIT 0
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2
`endif

// ==== ccp_pkg.sv ====
// types for the gas sensor command interpreter
package ccp_pkg;
    typedef enum logic [5:0] {
        ST_CMD = 6'h01,
        ST_SEP = 6'h02,
        ST_ARG = 6'h04,
        ST_LF = 6'h08,
        ST_DROP = 6'h10,
        ST_EXEC = 6'h20
    } ccp_state_t;
    typedef struct packed {
        logic [15:0] filt;
        logic [15:0] raw;
    } ccp_meas_t;
    typedef struct packed {
        logic [7:0] code;
        logic [16:0] arg;
        logic has_arg;
    } ccp_cmd_t;
endpackage

// ==== ccp_host_sink.sv ====
// reply sink standing in for the host
`timescale 1ns/100ps
module ccp_host_sink (
    input wire logic aclk,
    input wire logic slow,
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [7:0] tx_data
);
    logic [7:0] q[$];
    logic [1:0] cnt_r = 2'h0;
    // slow host is ready one cycle in four, so the reply fifo backs up
    assign tx_ready = !slow || (cnt_r == 2'h3);
    always @(posedge aclk) begin
        cnt_r <= cnt_r + 2'h1;
        if (tx_valid && tx_ready) q.push_back(tx_data);
    end
endmodule

// ==== tb.sv ====
// testbench for the command interpreter
`timescale 1ns/100ps
module tb;
    logic aclk = 1'b0, aresetn = 1'b0, rx_valid = 1'b0, slow = 1'b0;
    logic rx_ready, tx_valid, tx_ready, meas_en, save_poll;
    logic meas_busy = 1'b0, saved_poll = 1'b0;
    logic [7:0] rx_data = 8'h00, tx_data;
    ccp_pkg::ccp_meas_t meas = '{filt: 16'h0209, raw: 16'h0321};
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
    logic [31:0] s_axi_araddr = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready;
    logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int errors = 0, num_checks = 0;
    always #2 aclk = ~aclk;
    ccp_host_sink hu (.aclk, .slow, .tx_valid, .tx_ready, .tx_data);
    ccp_parser #(.REPORT_CYCLES(1000)) dut_u (.aclk, .aresetn, .rx_valid,
        .rx_ready, .rx_data, .tx_valid, .tx_ready, .tx_data, .meas,
        .meas_busy, .meas_en, .saved_poll, .save_poll, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    // ----
    // tasks
    // ----
    task automatic chk(input string w, input logic [31:0] s, x);
        num_checks++;
        if (s !== x) begin
            errors++;
            $display("ERROR %s expected %h seen %h", w, x, s);
        end
    endtask
    function automatic string ex(byte c, int v);
        return $sformatf("%c %05d\015\012", c, v);
    endfunction
    // valid held across a line, so no double drive between characters
    task automatic cmd(input string s, input string e);
        int n;
        n = 0;
        foreach (s[i]) begin
            rx_data <= s[i];
            rx_valid <= 1'b1;
            do @(negedge aclk); while (rx_ready !== 1'b1);
            @(posedge aclk);
        end
        rx_valid <= 1'b0;
        while (hu.q.size() < e.len() && n++ < 400) @(posedge aclk);
        repeat (40) @(posedge aclk);
        chk("count", hu.q.size(), e.len());
        foreach (e[i]) chk("tx", hu.q.size() ? hu.q.pop_front() : 8'hxx, e[i]);
        hu.q.delete();
    endtask
    task automatic axw(input logic [31:0] a, d);
        logic aw, w, b;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge aclk);
            aw = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            b = s_axi_bvalid;
            chk("bresp", b ? s_axi_bresp : 2'h0, 2'h0);
            @(posedge aclk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end while (!b);
        s_axi_bready <= 1'b0;
    endtask
    task automatic axr(input logic [31:0] a, output logic [31:0] d,
        output logic [1:0] r);
        logic ar, v;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge aclk);
            ar = s_axi_arvalid && s_axi_arready;
            v = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (ar) s_axi_arvalid <= 1'b0;
        end while (!v);
        s_axi_rready <= 1'b0;
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // ----
    // tests
    // ----
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        cmd("K 2\015\012", ex("K", 2));
        chk("save_poll", save_poll, 1);
        repeat (1100) @(posedge aclk);
        cmd("", "");
        $display("poll test done");
        cmd("Z\015\012", ex("Z", 521));
        cmd("z\015\012", ex("z", 801));
        cmd(".\015\012", ex(".", 10));
        axw(32'h0, 32'h1);
        cmd(".\015\012", ex(".", 100));
        axw(32'h0, 32'h0);
        $display("query test done");
        // no concentration is ever sent, so nothing to divide
        slow <= 1'b1;
        cmd("a\015\012", ex("a", 16));
        cmd("A 65535\015\012", ex("A", 65535));
        cmd("A 0\015\012", "");
        cmd("Q\015\012", "");
        cmd("a\015\012", ex("a", 65535));
        axr(32'h8, d, r);
        chk("filter", d, 32'hffff);
        axr(32'hc, d, r);
        chk("rresp", r, 2'h2);
        slow <= 1'b0;
        $display("filter test done");
        cmd("K 0\015\012", ex("K", 0));
        chk("meas_en", meas_en, 0);
        cmd("Z\015\012", "");
        cmd(".\015\012", ex(".", 10));
        cmd("K 1\015\012", ex("K", 1));
        repeat (1000) @(posedge aclk);
        cmd("", ex("Z", 521));
        meas_busy <= 1'b1;
        cmd("a\015\012", "");
        chk("rx_ready", rx_ready, 0);
        meas_busy <= 1'b0;
        cmd("", ex("a", 65535));
        cmd("K 0\015\012", ex("K", 0));
        saved_poll <= 1'b1;
        aresetn <= 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        axr(32'h4, d, r);
        chk("status", d, 32'h6);
        $display("sleep and stream test done");
        end_sim();
    end
    initial begin
        repeat (20000) @(posedge aclk);
        errors++;
        end_sim();
    end
endmodule
